//--- rtl/swb_map.svh
// constants shared by both ends of the single-wire sensor link
`ifndef SWB_MAP_SVH
`define SWB_MAP_SVH
`define SWB_DEVN_W 3
`define SWB_ADDR_W 6
`define SWB_TRAIN_BITS 3'h7
`define SWB_QUIET_BITS 4'hE
`define SWB_SLOT_GAP 3'h4
`define SWB_BCAST 3'h0
`define SWB_STRAP_LO 3'h1
`define SWB_STRAP_HI 3'h2
`define SWB_REG_DEVNUM 6'h00
`define SWB_REG_STATUS 6'h04
`define SWB_REG_CTRL 6'h05
`define SWB_REG_READOUT 6'h09
`define SWB_ST_BER 7
`define SWB_CTRL_EN_LO 4
`define SWB_CTRL_EN_HI 5
`define SWB_AXI_CMD 4'h0
`define SWB_AXI_WDATA 4'h4
`define SWB_AXI_STAT 4'h8
`define SWB_AXI_RDATA 4'hC
`define SWB_RESP_OK 2'h0
`define SWB_RESP_ERR 2'h2
`endif

//--- rtl/swb_pkg.sv
// types shared by both ends of the single-wire sensor link
`default_nettype none
package swb_pkg;
	typedef enum logic [1:0] {SWB_SYM_DATA, SWB_SYM_START, SWB_SYM_RESET} swb_sym_t;
	typedef enum logic [2:0] {SWB_D_IDLE, SWB_D_DEVN, SWB_D_ADDR, SWB_D_DIR, SWB_D_DATA,
		SWB_D_PAR, SWB_D_ACK, SWB_D_SKIP} swb_dst_t;
	typedef enum logic [1:0] {SWB_M_IDLE, SWB_M_RST, SWB_M_TRAIN, SWB_M_FRAME} swb_mst_t;
endpackage
`default_nettype wire

//--- rtl/swb_link_if.sv
// decoded bit-signal link between bus master and sensor slave
`default_nettype none
interface swb_link_if;
	import swb_pkg::*;
	logic slot;
	swb_sym_t sym;
	logic m_bit;
	logic s_bit;
	logic atn;
	logic bus_bit;
	// wired line: either party pulling long makes a one
	assign bus_bit = m_bit | s_bit;
	modport dev(input slot, input sym, input bus_bit, output s_bit, output atn);
	modport mst(input bus_bit, input atn, output slot, output sym, output m_bit);
endinterface
`default_nettype wire

//--- rtl/swb_dev.sv
// sensor slave end: transaction layer of the single-wire link
//
// What this block does
// - bus reset clears only the interface
// - master resets bus before any transaction
// - eight training zeros are plain traffic
// - start, number, address, direction, data, parity, ack
// - direction one reads, zero writes
// - broadcast ignored on reads, control writes accepted
// - data msb first, eight or sixteen bits
// - even parity over all fields plus itself
// - master acknowledges reads, one completes them
// - device acknowledges writes, update only on one
// - no acknowledge sets error, skips effects, attention
// - midframe start aborts silently and restarts
// - surplus data bits dropped, checked as parity
// - missing bits awaited forever, start aborts
// - event attention once, until status read
// - error attention always, unless bus reset
// - bit colliding with attention is dropped
// - master scans all status after attention; swb_mst only latches it in atnf for software
// - device number taken from strap pin
// - master probes device number, zero means absent
// - no attention before fourteen data bits
// - start bits watched at all times
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none
`include "swb_map.svh"
module swb_dev
	import swb_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	swb_link_if.dev link,
	input wire logic addr_strap_in,
	input wire logic [1:0] func_evt_in,
	input wire logic [15:0] readout_in,
	output logic [7:0] ctrl_out,
	output logic [7:0] status_out
);
	swb_dst_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [2:0] devn, next_devn;
	logic [5:0] addr, next_addr;
	logic rd, next_rd;
	logic par, next_par;
	logic ok, next_ok;
	logic [15:0] sh, next_sh;
	logic s_bit, next_s_bit;
	logic atn, next_atn;
	logic [2:0] devnum, next_devnum;
	logic strap_s1, strap_s2;
	logic [1:0] strap_cnt, next_strap_cnt;
	logic [7:0] stat, next_stat;
	logic [7:0] ctrl, next_ctrl;
	logic err_pend, next_err_pend;
	logic fn_pend, next_fn_pend;
	logic atn_seen, next_atn_seen;
	logic [3:0] quiet, next_quiet;
	logic take;
	logic len16;
	logic last;
	logic done;
	logic [15:0] rval;

	// strap pin comes from outside: two flops before use
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
		end
		else
		begin
			strap_s1 <= addr_strap_in;
			strap_s2 <= strap_s1;
		end
	end

	always_comb
	begin
		// a data or start slot that starts with our own attention is lost for both sides
		take = link.slot && !atn;
		len16 = (addr == `SWB_REG_READOUT);
		last = (cnt == (len16 ? 4'hF : 4'h7));
		done = 1'b0;
		unique case (addr)
			`SWB_REG_DEVNUM: rval = {13'h0000, devnum};
			`SWB_REG_STATUS: rval = {8'h00, stat};
			`SWB_REG_CTRL: rval = {8'h00, ctrl};
			`SWB_REG_READOUT: rval = readout_in;
			default: rval = 16'h0000;
		endcase
		next_st = st;
		next_cnt = cnt;
		next_devn = devn;
		next_addr = addr;
		next_rd = rd;
		next_par = par;
		next_ok = ok;
		next_sh = sh;
		next_s_bit = s_bit;
		next_atn = 1'b0;
		next_devnum = devnum;
		next_strap_cnt = strap_cnt;
		next_stat = stat;
		next_ctrl = ctrl;
		next_err_pend = err_pend;
		next_fn_pend = fn_pend;
		next_atn_seen = atn_seen;
		next_quiet = quiet;
		// number is caught a few edges after release, once the strap is settled
		if (strap_cnt != 2'h3)
		begin
			next_strap_cnt = strap_cnt + 2'h1;
			if (strap_cnt == 2'h2)
				next_devnum = strap_s2 ? `SWB_STRAP_HI : `SWB_STRAP_LO;
		end
		if (link.slot && link.sym == SWB_SYM_RESET)
		begin
			// registers, flags and control survive a bus reset
			next_st = SWB_D_IDLE;
			next_s_bit = 1'b0;
			next_err_pend = 1'b0;
			next_atn_seen = 1'b0;
			next_quiet = 4'h0;
		end
		else if (take && link.sym == SWB_SYM_START)
		begin
			next_st = SWB_D_DEVN;
			next_cnt = 4'h0;
			next_par = 1'b0;
			next_s_bit = 1'b0;
		end
		else if (take)
		begin
			if (quiet != `SWB_QUIET_BITS)
				next_quiet = quiet + 4'h1;
			unique case (st)
				SWB_D_DEVN:
				begin
					next_devn = {devn[1:0], link.bus_bit};
					next_par = par ^ link.bus_bit;
					next_cnt = cnt + 4'h1;
					if (cnt == 4'h2)
					begin
						next_st = SWB_D_ADDR;
						next_cnt = 4'h0;
					end
				end
				SWB_D_ADDR:
				begin
					next_addr = {addr[4:0], link.bus_bit};
					next_par = par ^ link.bus_bit;
					next_cnt = cnt + 4'h1;
					if (cnt == 4'h5)
						next_st = SWB_D_DIR;
				end
				SWB_D_DIR:
				begin
					next_rd = link.bus_bit;
					next_par = par ^ link.bus_bit;
					next_cnt = 4'h0;
					if ((devn == devnum && strap_cnt == 2'h3)
						|| (devn == `SWB_BCAST && !link.bus_bit && addr == `SWB_REG_CTRL))
					begin
						next_st = SWB_D_DATA;
						next_sh = len16 ? rval : {rval[7:0], 8'h00};
						next_s_bit = link.bus_bit & next_sh[15];
					end
					else
						next_st = SWB_D_SKIP;
				end
				SWB_D_DATA:
				begin
					next_par = par ^ link.bus_bit;
					next_cnt = cnt + 4'h1;
					next_sh = rd ? {sh[14:0], 1'b0} : {sh[14:0], link.bus_bit};
					next_s_bit = rd & sh[14];
					if (last)
					begin
						// the final data bit lands here; the next bit, even a surplus data bit, is judged as parity
						next_st = SWB_D_PAR;
						next_s_bit = rd & (par ^ link.bus_bit);
					end
				end
				SWB_D_PAR:
				begin
					next_st = SWB_D_ACK;
					next_ok = !(par ^ link.bus_bit);
					next_s_bit = !rd && next_ok;
				end
				SWB_D_ACK:
				begin
					next_st = SWB_D_SKIP;
					next_s_bit = 1'b0;
					done = rd ? link.bus_bit : ok;
					if (!done)
					begin
						next_stat[`SWB_ST_BER] = 1'b1;
						next_err_pend = 1'b1;
					end
					else if (!rd && addr == `SWB_REG_CTRL)
						next_ctrl = sh[7:0];
					else if (rd && addr == `SWB_REG_STATUS)
					begin
						next_stat = 8'h00;
						next_atn_seen = 1'b0;
					end
				end
				default:
				begin
					// idle and skip: training zeros and foreign frames pass by
					next_st = st;
				end
			endcase
		end
		// events land after any clear so a coinciding event is kept
		next_stat[1:0] = next_stat[1:0] | func_evt_in;
		if (|(func_evt_in & ctrl[`SWB_CTRL_EN_HI:`SWB_CTRL_EN_LO]))
			next_fn_pend = 1'b1;
		if (!link.slot && !atn && quiet == `SWB_QUIET_BITS)
		begin
			if (err_pend || (fn_pend && !atn_seen))
			begin
				next_atn = 1'b1;
				next_atn_seen = 1'b1;
				next_err_pend = 1'b0;
				next_fn_pend = 1'b0;
			end
			else if (fn_pend)
				next_fn_pend = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st <= SWB_D_IDLE;
			cnt <= 4'h0;
			devn <= 3'h0;
			addr <= 6'h00;
			rd <= 1'b0;
			par <= 1'b0;
			ok <= 1'b0;
			sh <= 16'h0000;
			s_bit <= 1'b0;
			atn <= 1'b0;
			devnum <= 3'h0;
			strap_cnt <= 2'h0;
			stat <= 8'h00;
			ctrl <= 8'h00;
			err_pend <= 1'b0;
			fn_pend <= 1'b0;
			atn_seen <= 1'b0;
			quiet <= 4'h0;
		end
		else
		begin
			st <= next_st;
			cnt <= next_cnt;
			devn <= next_devn;
			addr <= next_addr;
			rd <= next_rd;
			par <= next_par;
			ok <= next_ok;
			sh <= next_sh;
			s_bit <= next_s_bit;
			atn <= next_atn;
			devnum <= next_devnum;
			strap_cnt <= next_strap_cnt;
			stat <= next_stat;
			ctrl <= next_ctrl;
			err_pend <= next_err_pend;
			fn_pend <= next_fn_pend;
			atn_seen <= next_atn_seen;
			quiet <= next_quiet;
		end
	end

	assign link.s_bit = s_bit;
	assign link.atn = atn;
	assign ctrl_out = ctrl;
	assign status_out = stat;
endmodule // swb_dev
`default_nettype wire

//--- rtl/swb_mst.sv
// bus master end: axi4-lite command registers driving the link
`default_nettype none
`include "swb_map.svh"
module swb_mst
	import swb_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	swb_link_if.mst link,
	input wire logic [3:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [3:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in
);
	logic aw_got, next_aw_got, w_got, next_w_got;
	logic [3:0] wa, next_wa;
	logic [31:0] wd, next_wd;
	logic awrdy, next_awrdy, wrdy, next_wrdy, arrdy, next_arrdy;
	logic bval, next_bval, rval, next_rval;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdat, next_rdat;
	swb_mst_t st, next_st;
	logic [2:0] gap, next_gap, tcnt, next_tcnt;
	logic [4:0] pos, next_pos;
	logic [25:0] fr, next_fr;
	logic [15:0] wdat, next_wdat, rxd, next_rxd;
	logic rd, next_rd, len16, next_len16, par, next_par, ackv, next_ackv;
	logic ok, next_ok, atnf, next_atnf;
	logic slot, next_slot, m_bit, next_m_bit;
	swb_sym_t sym, next_sym;
	logic [4:0] pend;

	always_comb
	begin
		pend = len16 ? 5'h1B : 5'h13;
		next_aw_got = aw_got; next_w_got = w_got; next_wa = wa; next_wd = wd;
		next_bval = bval; next_rval = rval; next_bresp = bresp; next_rresp = rresp;
		next_rdat = rdat; next_st = st; next_gap = gap; next_tcnt = tcnt; next_pos = pos;
		next_fr = fr; next_wdat = wdat; next_rxd = rxd; next_rd = rd; next_len16 = len16;
		next_par = par; next_ackv = ackv; next_ok = ok; next_atnf = atnf;
		next_slot = 1'b0; next_m_bit = 1'b0; next_sym = sym;
		if (bval && bready_in)
			next_bval = 1'b0;
		if (rval && rready_in)
			next_rval = 1'b0;
		if (awvalid_in && awrdy)
		begin
			next_aw_got = 1'b1;
			next_wa = awaddr_in;
		end
		if (wvalid_in && wrdy)
		begin
			next_w_got = 1'b1;
			next_wd = wdata_in;
		end
		// the master records every attention until software clears it
		if (link.atn)
			next_atnf = 1'b1;
		if (next_aw_got && next_w_got && !next_bval)
		begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bval = 1'b1;
			next_bresp = `SWB_RESP_OK;
			unique case (next_wa)
				`SWB_AXI_CMD:
				begin
					if (next_wd[12] && wstrb_in[1])
						next_st = SWB_M_RST;
					else if (next_wd[11] && st == SWB_M_IDLE)
					begin
						next_st = SWB_M_FRAME;
						next_pos = 5'h00;
						next_rd = next_wd[9];
						next_len16 = next_wd[10];
						next_fr = {next_wd[2:0], next_wd[8:3], next_wd[9], next_wd[9] ? 16'h0000 :
							(next_wd[10] ? wdat : {wdat[7:0], 8'h00})};
					end
				end
				`SWB_AXI_WDATA: next_wdat = next_wd[15:0];
				`SWB_AXI_STAT: if (next_wd[2] && !link.atn) next_atnf = 1'b0;
				`SWB_AXI_RDATA: next_bresp = `SWB_RESP_OK;
				default: next_bresp = `SWB_RESP_ERR;
			endcase
		end
		if (arvalid_in && arrdy)
		begin
			next_rval = 1'b1;
			next_rresp = `SWB_RESP_OK;
			unique case (araddr_in)
				`SWB_AXI_STAT: next_rdat = {29'h00000000, atnf, ok, st != SWB_M_IDLE};
				`SWB_AXI_RDATA: next_rdat = {16'h0000, rxd};
				`SWB_AXI_CMD: next_rdat = 32'h00000000;
				`SWB_AXI_WDATA: next_rdat = {16'h0000, wdat};
				default:
				begin
					next_rdat = 32'h00000000;
					next_rresp = `SWB_RESP_ERR;
				end
			endcase
		end
		next_awrdy = !next_aw_got && !next_bval && !(awvalid_in && awrdy);
		next_wrdy = !next_w_got && !next_bval && !(wvalid_in && wrdy);
		next_arrdy = !next_rval && !(arvalid_in && arrdy);
		if (slot)
		begin
			// the cycle that finds the gap at zero counts toward the spacing, leaving four idle cycles between slots
			next_gap = `SWB_SLOT_GAP - 3'h1;
			// a bit that met an attention is sent again unchanged
			if (!link.atn || sym == SWB_SYM_RESET)
			begin
				unique case (st)
					SWB_M_RST:
					begin
						next_st = SWB_M_TRAIN;
						next_tcnt = 3'h0;
					end
					SWB_M_TRAIN:
					begin
						next_tcnt = tcnt + 3'h1;
						if (tcnt == `SWB_TRAIN_BITS)
							next_st = SWB_M_IDLE;
					end
					SWB_M_FRAME:
					begin
						next_pos = pos + 5'h01;
						if (pos != 5'h00 && pos < pend)
						begin
							next_par = par ^ link.bus_bit;
							next_fr = {fr[24:0], 1'b0};
							if (pos > 5'h0A)
								next_rxd = {rxd[14:0], link.bus_bit};
						end
						else if (pos == pend)
							next_ackv = !(par ^ link.bus_bit);
						else if (pos == pend + 5'h01)
						begin
							next_ok = rd ? ackv : link.bus_bit;
							next_st = SWB_M_IDLE;
						end
						if (pos == 5'h00)
							next_par = 1'b0;
					end
					default: next_st = st;
				endcase
			end
		end
		else if (gap != 3'h0)
			next_gap = gap - 3'h1;
		else if (st != SWB_M_IDLE && next_st == st)
		begin
			next_slot = 1'b1;
			next_sym = SWB_SYM_DATA;
			if (st == SWB_M_RST)
				next_sym = SWB_SYM_RESET;
			else if (st == SWB_M_FRAME && pos == 5'h00)
				next_sym = SWB_SYM_START;
			else if (st == SWB_M_FRAME && pos < pend)
				next_m_bit = fr[25];
			else if (st == SWB_M_FRAME && pos == pend)
				next_m_bit = !rd && par;
			else if (st == SWB_M_FRAME)
				next_m_bit = rd && ackv;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_got <= 1'b0; w_got <= 1'b0; wa <= 4'h0; wd <= 32'h00000000;
			awrdy <= 1'b0; wrdy <= 1'b0; arrdy <= 1'b0; bval <= 1'b0; rval <= 1'b0;
			bresp <= 2'h0; rresp <= 2'h0; rdat <= 32'h00000000;
			st <= SWB_M_RST; gap <= 3'h0; tcnt <= 3'h0; pos <= 5'h00;
			fr <= 26'h0000000; wdat <= 16'h0000; rxd <= 16'h0000; rd <= 1'b0;
			len16 <= 1'b0; par <= 1'b0; ackv <= 1'b0; ok <= 1'b0; atnf <= 1'b0;
			slot <= 1'b0; m_bit <= 1'b0; sym <= SWB_SYM_DATA;
		end
		else
		begin
			aw_got <= next_aw_got; w_got <= next_w_got; wa <= next_wa; wd <= next_wd;
			awrdy <= next_awrdy; wrdy <= next_wrdy; arrdy <= next_arrdy;
			bval <= next_bval; rval <= next_rval; bresp <= next_bresp;
			rresp <= next_rresp; rdat <= next_rdat;
			st <= next_st; gap <= next_gap; tcnt <= next_tcnt; pos <= next_pos;
			fr <= next_fr; wdat <= next_wdat; rxd <= next_rxd; rd <= next_rd;
			len16 <= next_len16; par <= next_par; ackv <= next_ackv; ok <= next_ok;
			atnf <= next_atnf; slot <= next_slot; m_bit <= next_m_bit; sym <= next_sym;
		end
	end

	assign awready_out = awrdy;
	assign wready_out = wrdy;
	assign bvalid_out = bval;
	assign bresp_out = bresp;
	assign arready_out = arrdy;
	assign rvalid_out = rval;
	assign rresp_out = rresp;
	assign rdata_out = rdat;
	assign link.slot = slot;
	assign link.sym = sym;
	assign link.m_bit = m_bit;
endmodule // swb_mst
`default_nettype wire

//--- tb/swb_link_assertions.sv
// link-side assertions for the single-wire sensor link
`default_nettype none
module swb_link_assertions
	import swb_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic slot,
	input wire swb_sym_t sym,
	input wire logic m_bit,
	input wire logic s_bit,
	input wire logic atn
);
	// data slots seen since the last bus reset, saturating
	logic [3:0] quiet;
	logic [3:0] next_quiet;
	always_comb
	begin
		next_quiet = quiet;
		if (slot && sym == SWB_SYM_RESET)
			next_quiet = 4'h0;
		else if (slot && sym == SWB_SYM_DATA && !atn && quiet != 4'hF)
			next_quiet = quiet + 4'h1;
	end
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			quiet <= 4'h0;
		else
			quiet <= next_quiet;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	AST_SLOT_GAP: assert property (slot |=> !slot [*4])
		else $error("slots closer than five cycles");
	AST_TRAIN: assert property (slot && sym == SWB_SYM_RESET |=> !slot [*4] ##1
		(slot && sym == SWB_SYM_DATA && !m_bit)) else $error("training zero missing");
	AST_SBIT_RESET: assert property (slot && sym == SWB_SYM_RESET |=> !s_bit)
		else $error("device line held after bus reset");
	AST_SBIT_STABLE: assert property (!$past(slot) |-> $stable(s_bit))
		else $error("device bit moved between slots");
	AST_MBIT_QUIET: assert property (!slot |-> !m_bit)
		else $error("master bit outside slot");
	AST_ATN_SLOT: assert property (atn |-> !$past(slot))
		else $error("attention launched during a slot");
	AST_ATN_PULSE: assert property (atn |=> !atn)
		else $error("attention longer than one cycle");
	AST_QUIET: assert property (atn |-> quiet >= 4'hE)
		else $error("attention too soon after bus reset");
endmodule // swb_link_assertions
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench joining master and sensor ends over the link
`default_nettype none
`include "swb_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, strap, awv, wv, bry, arv, rry;
	logic [1:0] fev;
	logic [15:0] rdo;
	logic [3:0] awa, ara;
	logic [31:0] wd, rdata, st, rdv;
	logic awr, wr, bv, arr, rv;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] ctrl, stat;
	int bad_count, cmp_count, cyc;
	swb_link_if link ();
	swb_dev swb_dev_inst (.core_clk_in(clk), .rstn_in(rstn), .link(link),
		.addr_strap_in(strap), .func_evt_in(fev), .readout_in(rdo), .ctrl_out(ctrl),
		.status_out(stat));
	swb_mst swb_mst_inst (.core_clk_in(clk), .rstn_in(rstn), .link(link),
		.awaddr_in(awa), .awvalid_in(awv), .awready_out(awr), .wdata_in(wd),
		.wstrb_in(4'hF), .wvalid_in(wv), .wready_out(wr), .bresp_out(bresp),
		.bvalid_out(bv), .bready_in(bry), .araddr_in(ara), .arvalid_in(arv),
		.arready_out(arr), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rv),
		.rready_in(rry));
	swb_link_assertions swb_link_assertions_inst (.core_clk_in(clk), .rstn_in(rstn),
		.slot(link.slot), .sym(link.sym), .m_bit(link.m_bit), .s_bit(link.s_bit),
		.atn(link.atn));
	always #5 clk = ~clk;
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// a long frame takes about 145 cycles; this ceiling is far above the whole run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// each task starts one edge late so no valid is assigned twice in a time step
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdata;
		r = rresp;
		rry <= 1'b0;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (2) @(posedge clk);
		do
		begin
			axr(`SWB_AXI_STAT, st, rsp);
			k++;
		end while (st[0] !== 1'b0 && k < 400);
		if (st[0] !== 1'b0)
			bad_count++;
	endtask
	task automatic frame(input logic [2:0] n, input logic [5:0] g, input logic r,
		input logic [15:0] d);
		axw(`SWB_AXI_WDATA, {16'h0, d});
		axw(`SWB_AXI_CMD, {20'h0, 1'b1, g == `SWB_REG_READOUT, r, g, n});
		wait_idle();
	endtask
	task automatic watch(input int n, output logic s);
		s = 1'b0;
		repeat (n) @(posedge clk) if (link.atn === 1'b1) s = 1'b1;
	endtask
	task automatic pulse(input logic [1:0] f);
		fev <= f;
		@(posedge clk);
		fev <= 2'b00;
	endtask
	task automatic t_boot();
		wait_idle();
		chk("busy", st[0], 1'b0);
		chk("ctrl", ctrl, 8'h00);
	endtask
	task automatic t_wr_rd();
		frame(3'h1, `SWB_REG_CTRL, 1'b0, 16'h00B1);
		chk("ctrl", ctrl, 8'hB1);
		chk("wr ack", st[1], 1'b1);
		rdo <= 16'h8C35;
		frame(3'h1, `SWB_REG_READOUT, 1'b1, 16'h0);
		chk("rd ack", st[1], 1'b1);
		axr(`SWB_AXI_RDATA, rdv, rsp);
		chk("readout", rdv[15:0], 16'h8C35);
		frame(3'h1, `SWB_REG_DEVNUM, 1'b1, 16'h0);
		axr(`SWB_AXI_RDATA, rdv, rsp);
		chk("number", rdv[7:0], 8'h01);
		frame(3'h3, `SWB_REG_DEVNUM, 1'b1, 16'h0);
		axr(`SWB_AXI_RDATA, rdv, rsp);
		chk("absent number", rdv[7:0], 8'h00);
		frame(3'h3, `SWB_REG_CTRL, 1'b0, 16'h0000);
		chk("other number", ctrl, 8'hB1);
	endtask
	task automatic t_bcast();
		frame(`SWB_BCAST, `SWB_REG_CTRL, 1'b0, 16'h0030);
		chk("bcast write", ctrl, 8'h30);
		frame(`SWB_BCAST, `SWB_REG_READOUT, 1'b1, 16'h0);
		axr(`SWB_AXI_RDATA, rdv, rsp);
		chk("bcast read", rdv[15:0], 16'h0000);
	endtask
	task automatic t_event();
		logic s;
		pulse(2'b01);
		watch(200, s);
		chk("atn", s, 1'b1);
		chk("flags", stat[1:0], 2'b01);
		axr(`SWB_AXI_STAT, st, rsp);
		chk("atn seen", st[2], 1'b1);
		pulse(2'b10);
		watch(200, s);
		chk("atn held back", s, 1'b0);
		frame(3'h1, `SWB_REG_STATUS, 1'b1, 16'h0);
		axr(`SWB_AXI_RDATA, rdv, rsp);
		chk("status read", rdv[7:0], 8'h03);
		chk("status cleared", stat, 8'h00);
		pulse(2'b01);
		watch(200, s);
		chk("atn after read", s, 1'b1);
	endtask
	task automatic t_busrst();
		logic s;
		axw(`SWB_AXI_CMD, 32'h0000_1000);
		wait_idle();
		chk("ctrl kept", ctrl, 8'h30);
		chk("status kept", stat, 8'h01);
		// only eight training bits have passed, short of the quiet count
		pulse(2'b10);
		watch(200, s);
		chk("atn quiet", s, 1'b0);
	endtask
	task automatic t_strap();
		rstn <= 1'b0;
		strap <= 1'b1;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		wait_idle();
		chk("ctrl reset", ctrl, 8'h00);
		frame(3'h1, `SWB_REG_CTRL, 1'b0, 16'h0044);
		chk("old number", ctrl, 8'h00);
		frame(3'h2, `SWB_REG_CTRL, 1'b0, 16'h0022);
		chk("new number", ctrl, 8'h22);
	endtask
	task automatic t_error();
		// 16-bit write to the 8-bit control register: ninth bit is judged as parity
		axw(`SWB_AXI_WDATA, 32'h0000_0000);
		axw(`SWB_AXI_CMD, {20'h0, 1'b1, 1'b1, 1'b0, `SWB_REG_CTRL, 3'h2});
		wait_idle();
		chk("surplus kept out", ctrl, 8'h22);
		chk("error flag", stat, 8'h80);
		chk("error nack", st[1], 1'b0);
		chk("error atn", st[2], 1'b1);
	endtask
	task automatic t_axi();
		axr(4'h2, rdv, rsp);
		chk("unmapped", rsp, `SWB_RESP_ERR);
	endtask
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		strap = 1'b0;
		fev = 2'b00;
		rdo = 16'h0;
		{awa, ara, wd} = '0;
		{awv, wv, bry, arv, rry} = '0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_boot();
		t_wr_rd();
		t_bcast();
		t_event();
		t_busrst();
		t_strap();
		t_error();
		t_axi();
		conclude();
	end
endmodule // testbench
`default_nettype wire
